// ==== pkg/rscl_pkg.sv ====
/*
 * Shared constants for the reset strap configuration loader: strap
 * pattern, configuration field positions, register offsets and timing.
 * Assumes a single 10 MHz clock common to both ends of the strap link.
 */
package rscl_pkg;

    // Timing
    localparam int HCLK_MHZ = 10;
    localparam int RESET_PHASE_NS = 1000;
    localparam int RESET_PHASE_CYC = (RESET_PHASE_NS * HCLK_MHZ + 999) / 1000;
    localparam int STRAP_HOLD_CYC = 2;
    localparam int CNT_W = 8;

    // Strap link
    localparam int STRAP_W = 16;
    localparam logic [15:0] STRAP_PATTERN = 16'h6808;
    localparam logic [15:0] STRAP_RSVD_MASK = 16'h0200;

    // Configuration register field positions
    localparam int CFG_CORE_PLL_MSB = 31;
    localparam int CFG_CORE_PLL_LSB = 27;
    localparam int CFG_XLB_DIV8 = 26;
    localparam int CFG_SYS_MUL12 = 25;
    localparam int CFG_VCO_X2 = 24;
    localparam int CFG_GFX_BOOT = 23;
    localparam int CFG_VEC_HIGH = 21;
    localparam int CFG_WAIT_LONG = 20;
    localparam int CFG_SWAP = 19;
    localparam int CFG_SIZE_BIG = 18;
    localparam int CFG_MUX = 17;
    localparam int CFG_LFLASH = 16;

    // Register offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_CONTROL = 8'h04;
    localparam logic [7:0] OFF_CLK_DIV = 8'h08;
    localparam logic [7:0] OFF_BOOT_CS = 8'h0C;
    localparam logic [7:0] OFF_CLK_STAT = 8'h10;
    localparam logic [7:0] OFF_VECTOR = 8'h14;

    // Control register
    localparam int CTL_RESET_REQ = 0;
    localparam int CTL_RUNNING = 1;

    // Clock divider register
    localparam int DIV_W = 4;
    localparam int DIV_PCI_LSB = 0;
    localparam int DIV_LPB_LSB = 4;
    localparam logic [3:0] PCI_DIV_RST = 4'h2;
    localparam logic [3:0] LPB_DIV_RST = 4'h1;

    // Boot chip-select attribute register
    localparam int BCS_W = 13;
    localparam int BCS_WAIT_LSB = 0;
    localparam int BCS_MUX = 8;
    localparam int BCS_SIZE_BIG = 9;
    localparam int BCS_SWAP = 10;
    localparam int BCS_LFLASH = 11;
    localparam int BCS_GFX = 12;
    localparam logic [7:0] BOOT_WAIT_SHORT = 8'h04;
    localparam logic [7:0] BOOT_WAIT_LONG = 8'h30;

    // Clock model
    localparam logic [11:0] REF_MHZ = 12'h021;
    localparam logic [11:0] SYS_MUL_LO = 12'h010;
    localparam logic [11:0] SYS_MUL_HI = 12'h00C;
    localparam logic [4:0] CORE_PLL_3X = 5'h02;
    localparam logic [11:0] CORE_RATIO_X2_3X = 12'h006;
    localparam logic [11:0] CORE_RATIO_X2_DEF = 12'h004;
    localparam int STAT_FIELD_W = 10;
    localparam int STAT_PCI_LSB = 0;
    localparam int STAT_XLB_LSB = 10;
    localparam int STAT_CORE_LSB = 20;

    // Exception vector bases
    localparam logic [31:0] VEC_BASE_LO = 32'h0000_0100;
    localparam logic [31:0] VEC_BASE_HI = 32'hFFF0_0100;

    typedef enum logic {
        ST_HOLD = 1'b0,
        ST_RUN = 1'b1
    } rscl_state_e;

endpackage

// ==== pkg/rscl_if.sv ====
/*
 * Strap link between the processor end and the strap driver end.
 * Assumes pull-ups on the strap pins: an undriven pin reads high.
 */
`timescale 1ns/100ps
interface rscl_if;
    logic hard_reset_n;
    logic [15:0] strap_out;
    logic [15:0] strap_oe;
    logic [15:0] strap_pin;

    // Resolved pin level; released pins float high
    assign strap_pin = (strap_out & strap_oe) | ~strap_oe;

    modport dev (
        input strap_pin,
        output hard_reset_n
    );
    modport drv (
        input hard_reset_n,
        output strap_out,
        output strap_oe
    );
endinterface

// ==== verilog/rscl_ahb_slave.sv ====
/*
 * AHB-Lite slave front end: single word transfers, OKAY only.
 * Assumes one slave on the bus, so hreadyout is the bus hready.
 */
`timescale 1ns/100ps
module rscl_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data
);
    logic addr_phase;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic rdy_q;
    logic [31:0] hrdata_q;
    logic unused_size;

    assign addr_phase = hsel & htrans[1] & hready;
    assign unused_size = |hsize;

    // Writes stretch their data phase by one cycle so a read that
    // follows at once already sees the new value.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdy_q <= 1'b1;
        end else if (addr_phase && hwrite) begin
            wr_pend_q <= 1'b1;
            wr_addr_q <= haddr[7:0];
            rdy_q <= 1'b0;
        end else begin
            wr_pend_q <= 1'b0;
            rdy_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata_q <= rd_data;
        end
    end

    assign rd_addr = haddr[7:0];
    assign wr_en = wr_pend_q;
    assign wr_addr = wr_addr_q;
    assign wr_data = hwdata;
    assign hreadyout = rdy_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
endmodule // rscl_ahb_slave

// ==== verilog/rscl_dev.sv ====
/*
 * Processor end of the reset strap loader: drives the hard reset,
 * captures the straps on its rising edge, keeps the configuration
 * read-only and derives clock and boot chip-select settings from it.
 * Assumes a strap driver on the rscl_if link and AHB-Lite software.
 */
// Behaviour
// - Driver presents straps during reset phase; after a software reset, from its second cycle
// - Driver releases straps after reset rises
// - Capture at reset rise; two-cycle hold
// - Captured configuration is read-only while running
// - Pins 0-4 give core PLL, bits 31-27
// - Bit 26 selects system bus VCO/4 or /8
// - Bit 25 selects VCO 16x or 12x
// - Bit 24 doubles the VCO when high
// - Bit 23 enables graphics boot mode
// - Bit 21 selects exception vector base
// - Bit 20 selects 4 or 48 wait clocks
// - Bit 19 swaps boot byte lanes
// - Bit 18 non-muxed: 8/24 or 16/16 bus
// - Bit 18 muxed: 16 or 32 bit data
// - Bit 17 selects muxed or single-tenure boot
// - Bit 16 from pin 15 selects large flash
// - Boot attributes affect boot chip select, reprogrammable
// - PCI and local bus dividers stay reprogrammable
// - Module straps give 132/66/396 MHz clocks
// - Driver also makes two SRAM byte selects
`timescale 1ns/100ps
module rscl_dev (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    rscl_if.dev link,
    output logic core_running,
    output logic [12:0] boot_cs_attr
);
    rscl_pkg::rscl_state_e state_q;
    logic [rscl_pkg::CNT_W-1:0] cnt_q;
    logic hard_reset_n_q;
    logic [31:0] cfg_q;
    logic [31:0] cap;
    logic [rscl_pkg::BCS_W-1:0] boot_cs_q;
    logic [rscl_pkg::BCS_W-1:0] boot_cs_cap;
    logic [3:0] pci_div_q;
    logic [3:0] lpb_div_q;
    logic [31:0] clk_stat_q;
    logic [31:0] clk_stat_d;
    logic [31:0] vector_q;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic capture;
    logic reset_req;

    rscl_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // Pin n lands in bit 31-n; the unassigned pin reads as zero
    for (genvar i = 0; i < rscl_pkg::STRAP_W; i++) begin : g_map
        assign cap[31-i] = link.strap_pin[i] &
            ~rscl_pkg::STRAP_RSVD_MASK[i];
    end
    assign cap[15:0] = 16'h0000;

    assign capture = (state_q == rscl_pkg::ST_HOLD) &&
        (cnt_q == rscl_pkg::CNT_W'(rscl_pkg::RESET_PHASE_CYC - 1));
    assign reset_req = (state_q == rscl_pkg::ST_RUN) && wr_en &&
        (wr_addr == rscl_pkg::OFF_CONTROL) &&
        wr_data[rscl_pkg::CTL_RESET_REQ];

    // Hard reset sequencing. Straps are sampled on the very edge that
    // raises the hard reset, while the driver still holds them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= rscl_pkg::ST_HOLD;
            cnt_q <= '0;
            hard_reset_n_q <= 1'b0;
        end else begin
            unique case (state_q)
                rscl_pkg::ST_HOLD: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (capture) begin
                        state_q <= rscl_pkg::ST_RUN;
                        hard_reset_n_q <= 1'b1;
                    end
                end
                rscl_pkg::ST_RUN: begin
                    if (reset_req) begin
                        state_q <= rscl_pkg::ST_HOLD;
                        cnt_q <= '0;
                        hard_reset_n_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Only a hard reset reloads the configuration; no bus write can
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= 32'h0000_0000;
        end else if (capture) begin
            cfg_q <= cap;
        end
    end

    // Boot chip-select attributes as loaded from the straps
    always_comb begin
        boot_cs_cap = '0;
        boot_cs_cap[rscl_pkg::BCS_WAIT_LSB +: 8] =
            cap[rscl_pkg::CFG_WAIT_LONG] ?
            rscl_pkg::BOOT_WAIT_LONG : rscl_pkg::BOOT_WAIT_SHORT;
        boot_cs_cap[rscl_pkg::BCS_MUX] = cap[rscl_pkg::CFG_MUX];
        // Width meaning depends on the mux bit beside it
        boot_cs_cap[rscl_pkg::BCS_SIZE_BIG] =
            cap[rscl_pkg::CFG_SIZE_BIG];
        boot_cs_cap[rscl_pkg::BCS_SWAP] = cap[rscl_pkg::CFG_SWAP];
        boot_cs_cap[rscl_pkg::BCS_LFLASH] =
            cap[rscl_pkg::CFG_LFLASH];
        boot_cs_cap[rscl_pkg::BCS_GFX] =
            cap[rscl_pkg::CFG_GFX_BOOT];
    end

    // Loaded at capture, but software may retune boot accesses later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_cs_q <= '0;
        end else if (capture) begin
            boot_cs_q <= boot_cs_cap;
        end else if (wr_en && wr_addr == rscl_pkg::OFF_BOOT_CS) begin
            boot_cs_q <= wr_data[rscl_pkg::BCS_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vector_q <= rscl_pkg::VEC_BASE_LO;
        end else if (capture) begin
            vector_q <= cap[rscl_pkg::CFG_VEC_HIGH] ?
                rscl_pkg::VEC_BASE_HI : rscl_pkg::VEC_BASE_LO;
        end
    end

    // Divider of zero would stop the clock, so it is stored as one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pci_div_q <= rscl_pkg::PCI_DIV_RST;
            lpb_div_q <= rscl_pkg::LPB_DIV_RST;
        end else if (wr_en && wr_addr == rscl_pkg::OFF_CLK_DIV) begin
            pci_div_q <= (wr_data[rscl_pkg::DIV_PCI_LSB +: 4] == 4'h0) ?
                4'h1 : wr_data[rscl_pkg::DIV_PCI_LSB +: 4];
            lpb_div_q <= (wr_data[rscl_pkg::DIV_LPB_LSB +: 4] == 4'h0) ?
                4'h1 : wr_data[rscl_pkg::DIV_LPB_LSB +: 4];
        end
    end

    // Frequencies in MHz that the current settings produce
    always_comb begin
        logic [11:0] vco;
        logic [11:0] xlb;
        logic [11:0] core;
        logic [11:0] pci;
        vco = 12'h000;
        xlb = 12'h000;
        core = 12'h000;
        pci = 12'h000;
        vco = rscl_pkg::REF_MHZ * (cfg_q[rscl_pkg::CFG_SYS_MUL12] ?
            rscl_pkg::SYS_MUL_HI : rscl_pkg::SYS_MUL_LO);
        if (cfg_q[rscl_pkg::CFG_VCO_X2]) begin
            vco = vco << 1;
        end
        xlb = cfg_q[rscl_pkg::CFG_XLB_DIV8] ? (vco >> 3) :
            (vco >> 2);
        core = (xlb * ((cfg_q[rscl_pkg::CFG_CORE_PLL_MSB:
            rscl_pkg::CFG_CORE_PLL_LSB] == rscl_pkg::CORE_PLL_3X) ?
            rscl_pkg::CORE_RATIO_X2_3X :
            rscl_pkg::CORE_RATIO_X2_DEF)) >> 1;
        pci = xlb / {8'h00, pci_div_q};
        clk_stat_d = '0;
        clk_stat_d[rscl_pkg::STAT_PCI_LSB +: 10] = pci[9:0];
        clk_stat_d[rscl_pkg::STAT_XLB_LSB +: 10] = xlb[9:0];
        clk_stat_d[rscl_pkg::STAT_CORE_LSB +: 10] = core[9:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_stat_q <= 32'h0000_0000;
        end else begin
            clk_stat_q <= clk_stat_d;
        end
    end

    // Register read map; unmapped offsets read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            rscl_pkg::OFF_CONFIG: rd_data = cfg_q;
            rscl_pkg::OFF_CONTROL: begin
                rd_data[rscl_pkg::CTL_RUNNING] = hard_reset_n_q;
            end
            rscl_pkg::OFF_CLK_DIV: begin
                rd_data[rscl_pkg::DIV_PCI_LSB +: 4] = pci_div_q;
                rd_data[rscl_pkg::DIV_LPB_LSB +: 4] = lpb_div_q;
            end
            rscl_pkg::OFF_BOOT_CS: rd_data[rscl_pkg::BCS_W-1:0] = boot_cs_q;
            rscl_pkg::OFF_CLK_STAT: rd_data = clk_stat_q;
            rscl_pkg::OFF_VECTOR: rd_data = vector_q;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    assign link.hard_reset_n = hard_reset_n_q;
    assign core_running = hard_reset_n_q;
    assign boot_cs_attr = boot_cs_q;
endmodule // rscl_dev

// ==== verilog/rscl_drv.sv ====
/*
 * Strap driver end: holds the fixed strap pattern on the pins from
 * power-up through hard reset, releases them afterwards, and makes
 * the two SRAM byte selects. Assumes hard_reset_n is synchronous.
 */
`timescale 1ns/100ps
module rscl_drv (
    input wire logic hclk,
    input wire logic hresetn,
    rscl_if.drv link,
    input wire logic sram_sel,
    input wire logic sram_a0,
    input wire logic sram_byte,
    output logic [1:0] sram_bs_n
);
    logic [15:0] out_q;
    logic oe_q;
    logic hr_prev_q;
    logic [rscl_pkg::CNT_W-1:0] hold_q;
    logic holding_q;
    logic [1:0] bs_n_q;

    // Pattern is a constant, so it is valid with no software at all
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_q <= rscl_pkg::STRAP_PATTERN;
        end else begin
            out_q <= rscl_pkg::STRAP_PATTERN;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_q <= 1'b1;
            hr_prev_q <= 1'b0;
            hold_q <= '0;
            holding_q <= 1'b0;
        end else begin
            hr_prev_q <= link.hard_reset_n;
            if (!link.hard_reset_n) begin
                oe_q <= 1'b1;
                holding_q <= 1'b0;
                hold_q <= '0;
            end else if (!hr_prev_q) begin
                holding_q <= 1'b1;
                hold_q <= rscl_pkg::CNT_W'(1);
            end else if (holding_q) begin
                if (hold_q == rscl_pkg::CNT_W'(rscl_pkg::STRAP_HOLD_CYC - 1))
                begin
                    oe_q <= 1'b0;
                    holding_q <= 1'b0;
                end else begin
                    hold_q <= hold_q + 1'b1;
                end
            end
        end
    end

    // Low lane on even byte or halfword, high lane on odd or halfword
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bs_n_q <= 2'h3;
        end else begin
            bs_n_q[0] <= ~(sram_sel & (~sram_byte | ~sram_a0));
            bs_n_q[1] <= ~(sram_sel & (~sram_byte | sram_a0));
        end
    end

    assign link.strap_out = out_q;
    assign link.strap_oe = {rscl_pkg::STRAP_W{oe_q}};
    assign sram_bs_n = bs_n_q;
endmodule // rscl_drv

// ==== verif/rscl_assertions.sv ====
/*
 * Checker for the strap link that joins the processor end and the
 * strap driver end. Assumes one clock and reset shared by both ends.
 */
`timescale 1ns/100ps
module rscl_assertions (
    input logic hclk,
    input logic hresetn,
    input logic hard_reset_n,
    input logic [15:0] strap_out,
    input logic [15:0] strap_oe,
    input logic [15:0] strap_pin
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_DRIVEN_IN_RESET: assert property (
        !hard_reset_n && !$past(hard_reset_n) |-> &strap_oe)
        else $error("straps not driven during hard reset");
    AST_PIN_PATTERN: assert property (
        !hard_reset_n && !$past(hard_reset_n)
        |-> strap_pin == rscl_pkg::STRAP_PATTERN)
        else $error("strap pins differ from the fixed pattern");
    AST_OUT_PATTERN: assert property (
        &strap_oe |-> strap_out == rscl_pkg::STRAP_PATTERN)
        else $error("driven strap value differs from the pattern");
    // Capture edge plus two more edges of stable pins
    AST_HOLD_TWO: assert property (
        $rose(hard_reset_n) |-> (&strap_oe && $stable(strap_pin)) [*2])
        else $error("straps not held two cycles after capture");
    AST_RELEASE: assert property (
        $rose(hard_reset_n) |-> ##2 strap_oe == 16'h0000)
        else $error("straps not released after hold");
    AST_STAY_RELEASED: assert property (
        hard_reset_n [*3] |-> strap_oe == 16'h0000)
        else $error("straps driven while running");
    AST_OE_UNIFORM: assert property (
        strap_oe == 16'h0000 || strap_oe == 16'hFFFF)
        else $error("strap enables split");
    AST_PHASE_LEN: assert property (
        $fell(hard_reset_n) |-> !hard_reset_n [*8])
        else $error("hard reset phase too short");
    AST_PHASE_END: assert property (
        $fell(hard_reset_n) |-> ##[8:14] hard_reset_n)
        else $error("hard reset phase does not end");
    AST_OE_RETURN: assert property (
        $fell(hard_reset_n) |-> ##[0:2] &strap_oe)
        else $error("straps not driven again after reset entry");

    COV_CAPTURE: cover property ($rose(hard_reset_n));
    COV_SOFT_RESET: cover property ($fell(hard_reset_n));
    COV_RELEASED: cover property (strap_oe == 16'h0000);
endmodule // rscl_assertions

// ==== verif/testbench.sv ====
/*
 * Self-checking bench: both ends joined on one link, AHB-Lite master
 * tasks and an integer model of the configuration and clocks.
 * Assumes the shared package, the link interface and both ends.
 */
`timescale 1ns/100ps
module testbench;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, core_running;
    logic [31:0] hrdata;
    logic [12:0] boot_cs_attr, bcs;
    logic sram_sel = 1'h0;
    logic sram_a0 = 1'h0;
    logic sram_byte = 1'h0;
    logic [1:0] sram_bs_n, bs;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 69;
    int vco, xlb, core;
    logic [31:0] cfg, rd, rv, e;
    logic [31:0] exp_q[$];
    logic [7:0] adr_q[$];

    always #50 hclk = ~hclk;

    rscl_if link_if();
    rscl_dev u_rscl_dev (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .link(link_if),
        .core_running(core_running), .boot_cs_attr(boot_cs_attr));
    rscl_drv u_rscl_drv (.hclk(hclk), .hresetn(hresetn), .link(link_if),
        .sram_sel(sram_sel), .sram_a0(sram_a0), .sram_byte(sram_byte),
        .sram_bs_n(sram_bs_n));
    rscl_assertions u_rscl_assertions (.hclk(hclk), .hresetn(hresetn),
        .hard_reset_n(link_if.hard_reset_n), .strap_out(link_if.strap_out),
        .strap_oe(link_if.strap_oe), .strap_pin(link_if.strap_pin));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Holds the request until hready is sampled high, as the bus demands
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask

    task automatic wait_run();
        for (int i = 0; i < 40 && link_if.hard_reset_n !== 1'h1; i++)
            @(posedge hclk);
        @(posedge hclk);
        check("running", {31'h0000_0000, core_running}, 32'h0000_0001);
    endtask

    task automatic read_all();
        foreach (adr_q[i]) begin
            xfer(adr_q[i], 1'h0, 32'h0000_0000, rd);
            check($sformatf("reg %h", adr_q[i]), rd, exp_q[i]);
            check("response", {31'h0, hresp}, 32'h0);
        end
    endtask

    initial begin
        cfg = 32'h0000_0000;
        for (int n = 0; n < 16; n++)
            if (n != 9)
                cfg[31 - n] = rscl_pkg::STRAP_PATTERN[n];
        vco = 33 * (cfg[25] ? 12 : 16) * (cfg[24] ? 2 : 1);
        xlb = vco / (cfg[26] ? 8 : 4);
        core = xlb * (cfg[31:27] == rscl_pkg::CORE_PLL_3X ? 3 : 2);
        bcs = {cfg[23], cfg[16], cfg[19], cfg[18], cfg[17],
               cfg[20] ? 8'h30 : 8'h04};
        adr_q = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h40};
        exp_q = '{cfg, 32'h0000_0002, 32'h0000_0012, {19'h0_0000, bcs},
                  {2'h0, core[9:0], xlb[9:0], 10'(xlb / 2)},
                  cfg[21] ? 32'hFFF0_0100 : 32'h0000_0100, 32'h0000_0000};
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        wait_run();
        read_all();
        // Read-only and unmapped places must ignore writes
        foreach (adr_q[i])
            if (adr_q[i] != 8'h04 && adr_q[i] != 8'h08 && adr_q[i] != 8'h0C)
                xfer(adr_q[i], 1'h1, $random(seed), rd);
        read_all();
        for (int k = 0; k < 3; k++) begin
            rv = (k == 0) ? 32'h0000_0000 : $random(seed);
            e = {24'h00_0000, rv[7:4] == 4'h0 ? 4'h1 : rv[7:4],
                 rv[3:0] == 4'h0 ? 4'h1 : rv[3:0]};
            xfer(8'h08, 1'h1, {24'h00_0000, rv[7:0]}, rd);
            xfer(8'h08, 1'h0, 32'h0000_0000, rd);
            check("clock divider", rd, e);
        end
        xfer(8'h08, 1'h1, 32'h0000_0012, rd);
        rv = $random(seed);
        xfer(8'h0C, 1'h1, {19'h0_0000, rv[12:0]}, rd);
        xfer(8'h0C, 1'h0, 32'h0000_0000, rd);
        check("boot cs", rd, {19'h0_0000, rv[12:0]});
        check("boot attr", {19'h0_0000, boot_cs_attr},
              {19'h0_0000, rv[12:0]});
        // Software restart recaptures straps and reloads boot attributes
        xfer(8'h04, 1'h1, 32'h0000_0001, rd);
        for (int i = 0; i < 8 && link_if.hard_reset_n !== 1'h0; i++)
            @(posedge hclk);
        check("hard reset", {31'h0, link_if.hard_reset_n}, 32'h0);
        wait_run();
        read_all();
        for (int k = 0; k < 16; k++) begin
            rv = $random(seed);
            sram_sel <= rv[0];
            sram_a0 <= rv[1];
            sram_byte <= rv[2];
            repeat (2) @(posedge hclk);
            bs[0] = !(rv[0] && (!rv[2] || !rv[1]));
            bs[1] = !(rv[0] && (!rv[2] || rv[1]));
            check("byte selects", {30'h0, sram_bs_n}, {30'h0, bs});
        end
        wrap_up();
    end

    // Whole run is under two hundred cycles; this only cuts off a hang
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        wrap_up();
    end
endmodule // testbench
